// ---- common/sdcd_pkg.sv ----
// Notes on behaviour
// - Commands decode from CS, RAS, CAS, WE and clock enable at the rising edge.
// - Mode register set: bank address picks the mode register, address carries opcode.
// - Bank commands act on the bank named by the bank address.
// - Valid inputs are driven by the controller; don't-care inputs are ignored.
// - A started read or write burst always completes; nothing cuts it short.
// - Fixed or on-the-fly burst length comes from mode register, not the command.
// - Write is CS low, RAS high, CAS low, WE low, clock enable high twice.
// - Read is CS low, RAS high, CAS low, WE high; column on low address bits.
// - Address bit 10 on read or write selects auto precharge when high.
// - On-the-fly write: bit 12 low gives chop of four, high gives eight.
// - On-the-fly read: bit 12 high gives eight beats, low gives four.
// - Activate takes a row address; read and write take a column address.
// - Bank, row and column widths are parameters set by density.
// - No refresh operation is performed while in power-down.
// - Termination input never affects decoding and is off during self refresh.
// - Self refresh exit is seen from clock enable high, not clock history.
// - No-operation never ends an operation in progress, such as a burst.
// - Deselect behaves exactly like no-operation.
`default_nettype none
package sdcd_pkg;

  localparam logic [11:0] SDCD_OFF_CTRL   = 12'h000;
  localparam logic [11:0] SDCD_OFF_STATUS = 12'h004;
  localparam logic [11:0] SDCD_OFF_LAST   = 12'h008;
  localparam logic [11:0] SDCD_OFF_MR0    = 12'h010;
  localparam logic [11:0] SDCD_OFF_MR3    = 12'h01C;

  localparam int          SDCD_CTRL_TERM_BIT = 0;
  localparam logic        SDCD_CTRL_TERM_RST = 1'b1;
  localparam int          SDCD_ST_ERR_CUT    = 8;
  localparam int          SDCD_ST_ERR_ILL    = 9;
  localparam int          SDCD_ST_BURST      = 4;
  localparam int          SDCD_ST_BURST_WR   = 5;

  localparam int          SDCD_AP_BIT = 10;
  localparam int          SDCD_BC_BIT = 12;

  localparam logic [1:0]  SDCD_BL_FIXED8 = 2'h0;
  localparam logic [1:0]  SDCD_BL_OTF    = 2'h1;
  localparam logic [1:0]  SDCD_BL_FIXED4 = 2'h2;

  localparam logic [2:0]  SDCD_BURST_CYC_BL8 = 3'h4;
  localparam logic [2:0]  SDCD_BURST_CYC_BC4 = 3'h2;

  typedef enum logic [4:0] {
    SDCD_CMD_NOP  = 5'h00,
    SDCD_CMD_DES  = 5'h01,
    SDCD_CMD_MRS  = 5'h02,
    SDCD_CMD_REF  = 5'h03,
    SDCD_CMD_SRE  = 5'h04,
    SDCD_CMD_SRX  = 5'h05,
    SDCD_CMD_PRE  = 5'h06,
    SDCD_CMD_PREA = 5'h07,
    SDCD_CMD_ACT  = 5'h08,
    SDCD_CMD_WR   = 5'h09,
    SDCD_CMD_RD   = 5'h0A,
    SDCD_CMD_ZQCL = 5'h0B,
    SDCD_CMD_ZQCS = 5'h0C,
    SDCD_CMD_PDE  = 5'h0D,
    SDCD_CMD_PDX  = 5'h0E,
    SDCD_CMD_HOLD = 5'h0F,
    SDCD_CMD_ILL  = 5'h10
  } sdcd_cmd_t;

  typedef enum logic [1:0] {
    SDCD_ST_NORMAL = 2'h0,
    SDCD_ST_PDN    = 2'h1,
    SDCD_ST_SREF   = 2'h2
  } sdcd_state_t;

endpackage : sdcd_pkg
`default_nettype wire

// ---- core/sdcd_core.sv ----
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sdcd_core
  import sdcd_pkg::*;
#(
  parameter int BA_W  = 3,
  parameter int ROW_W = 14,
  parameter int COL_W = 10
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              cke,
  input  wire logic              cs_n,
  input  wire logic              ras_n,
  input  wire logic              cas_n,
  input  wire logic              we_n,
  input  wire logic [BA_W-1:0]   ba,
  input  wire logic [ROW_W-1:0]  addr,
  input  wire logic              odt,
  output logic                   cmd_valid,
  output logic      [4:0]        cmd_code,
  output logic      [BA_W-1:0]   cmd_bank,
  output logic      [ROW_W-1:0]  row_addr,
  output logic      [COL_W-1:0]  column_addr,
  output logic                   auto_precharge_flag,
  output logic                   burst_chop_select,
  output logic                   burst_active,
  output logic                   burst_write,
  output logic                   refresh_pulse,
  output logic                   power_down,
  output logic                   self_refresh,
  output logic                   self_refresh_exit,
  output logic                   termination_on,
  output logic      [(1<<BA_W)-1:0] banks_open
);

  localparam int BANKS = 1 << BA_W;

  typedef struct packed {
    sdcd_state_t              st;
    logic                     cke_prev;
    logic [BANKS-1:0]         bank_open;
    logic [2:0]               burst_cnt;
    logic                     burst_wr;
    logic                     burst_ap;
    logic [BA_W-1:0]          burst_bank;
    logic [3:0][ROW_W-1:0]    mr;
    logic                     ctrl_term;
    logic                     err_cut;
    logic                     err_ill;
    logic [4:0]               last_cmd;
    logic                     cmd_valid;
    logic [4:0]               cmd;
    logic [BA_W-1:0]          bank;
    logic [ROW_W-1:0]         row;
    logic [COL_W-1:0]         col;
    logic                     ap;
    logic                     bc4;
    logic [31:0]              prdata;
  } sdcd_regs_t;

  sdcd_regs_t q;
  sdcd_regs_t d;

  // Pure strobe decode; the don't-care inputs never reach it when deselected
  function automatic sdcd_cmd_t sdcd_decode(input logic cke_p, input logic cke_n,
                                            input logic c_n, input logic r_n,
                                            input logic ca_n, input logic w_n);
    logic nop_like;
    nop_like = c_n | (r_n & ca_n & w_n);
    if (!cke_p && !cke_n) begin
      return SDCD_CMD_HOLD;
    end
    if (!cke_p && cke_n) begin
      return nop_like ? SDCD_CMD_PDX : SDCD_CMD_ILL;
    end
    if (cke_p && !cke_n) begin
      if (nop_like) begin
        return SDCD_CMD_PDE;
      end
      return (!r_n && !ca_n && w_n) ? SDCD_CMD_SRE : SDCD_CMD_ILL;
    end
    if (c_n) begin
      return SDCD_CMD_DES;
    end
    unique case ({r_n, ca_n, w_n})
      3'b000: return SDCD_CMD_MRS;
      3'b001: return SDCD_CMD_REF;
      3'b010: return SDCD_CMD_PRE;
      3'b011: return SDCD_CMD_ACT;
      3'b100: return SDCD_CMD_WR;
      3'b101: return SDCD_CMD_RD;
      3'b110: return SDCD_CMD_ZQCL;
      3'b111: return SDCD_CMD_NOP;
    endcase
  endfunction : sdcd_decode

  function automatic logic sdcd_mapped(input logic [11:0] a);
    return (a == SDCD_OFF_CTRL) || (a == SDCD_OFF_STATUS) || (a == SDCD_OFF_LAST) ||
           ((a >= SDCD_OFF_MR0) && (a <= SDCD_OFF_MR3) && (a[1:0] == 2'h0));
  endfunction : sdcd_mapped

  sdcd_cmd_t cmd;
  logic      apb_access;
  logic      ap_bit;
  logic      bc4_sel;
  logic      col_busy;

  // Zero wait states: the read word is captured in the setup cycle
  assign pready     = 1'b1;
  assign apb_access = psel & penable;
  assign pslverr    = apb_access & ~sdcd_mapped(paddr);
  assign ap_bit     = addr[SDCD_AP_BIT];

  // Burst mode comes only from the stored mode register 0 field
  always_comb begin
    unique case (q.mr[0][1:0])
      SDCD_BL_OTF:    bc4_sel = ~addr[SDCD_BC_BIT];
      SDCD_BL_FIXED4: bc4_sel = 1'b1;
      default:        bc4_sel = 1'b0;
    endcase
  end

  // A new column command may only chain onto the last beat pair of a burst
  assign col_busy = (q.burst_cnt > 3'h1);

  always_comb begin
    d           = q;
    d.cmd_valid = 1'b0;
    d.cke_prev  = cke;
    cmd         = sdcd_decode(q.cke_prev, cke, cs_n, ras_n, cas_n, we_n);

    if (q.burst_cnt != 3'h0) begin
      d.burst_cnt = q.burst_cnt - 3'h1;
      if (q.burst_cnt == 3'h1 && q.burst_ap) begin
        d.bank_open[q.burst_bank] = 1'b0;
      end
    end

    if (psel && !penable) begin
      d.prdata = 32'h0000_0000;
      if (paddr == SDCD_OFF_CTRL) begin
        d.prdata[SDCD_CTRL_TERM_BIT] = q.ctrl_term;
      end else if (paddr == SDCD_OFF_STATUS) begin
        d.prdata[1:0]              = q.st;
        d.prdata[SDCD_ST_BURST]    = (q.burst_cnt != 3'h0);
        d.prdata[SDCD_ST_BURST_WR] = q.burst_wr;
        d.prdata[SDCD_ST_ERR_CUT]  = q.err_cut;
        d.prdata[SDCD_ST_ERR_ILL]  = q.err_ill;
        d.prdata[16 +: BANKS]      = q.bank_open;
      end else if (paddr == SDCD_OFF_LAST) begin
        d.prdata[4:0] = q.last_cmd;
      end else if (sdcd_mapped(paddr)) begin
        d.prdata[ROW_W-1:0] = q.mr[paddr[3:2]];
      end
    end

    if (apb_access && pwrite) begin
      if (paddr == SDCD_OFF_CTRL) begin
        d.ctrl_term = pwdata[SDCD_CTRL_TERM_BIT];
      end else if (paddr == SDCD_OFF_STATUS) begin
        // Cleared first so a fresh error in the same cycle survives
        d.err_cut = q.err_cut & ~pwdata[SDCD_ST_ERR_CUT];
        d.err_ill = q.err_ill & ~pwdata[SDCD_ST_ERR_ILL];
      end
    end

    if (q.st == SDCD_ST_SREF) begin
      cmd = cke ? SDCD_CMD_SRX : SDCD_CMD_HOLD;
    end else if (q.st == SDCD_ST_PDN && cmd != SDCD_CMD_PDX && cmd != SDCD_CMD_ILL) begin
      // Only the wake-up or an illegal exit attempt passes, so no refresh can slip in while asleep
      cmd = SDCD_CMD_HOLD;
    end
    if (cmd == SDCD_CMD_PRE && ap_bit) begin
      cmd = SDCD_CMD_PREA;
    end
    if (cmd == SDCD_CMD_ZQCL && !ap_bit) begin
      cmd = SDCD_CMD_ZQCS;
    end
    if ((cmd == SDCD_CMD_WR || cmd == SDCD_CMD_RD) && col_busy) begin
      d.err_cut = 1'b1;
      cmd       = SDCD_CMD_NOP;
    end

    if (cmd != SDCD_CMD_HOLD && cmd != SDCD_CMD_NOP && cmd != SDCD_CMD_DES) begin
      d.cmd_valid = 1'b1;
      d.cmd       = cmd;
      d.last_cmd  = cmd;
      d.bank      = ba;
      d.ap        = ap_bit;
      d.bc4       = 1'b0;
    end

    unique case (cmd)
      SDCD_CMD_MRS: begin
        d.mr[ba[1:0]] = addr;
      end
      SDCD_CMD_SRE: begin
        d.st = SDCD_ST_SREF;
      end
      SDCD_CMD_SRX: begin
        d.st = SDCD_ST_NORMAL;
      end
      SDCD_CMD_PDE: begin
        d.st = SDCD_ST_PDN;
      end
      SDCD_CMD_PDX: begin
        d.st = SDCD_ST_NORMAL;
      end
      SDCD_CMD_PRE: begin
        d.bank_open[ba] = 1'b0;
      end
      SDCD_CMD_PREA: begin
        d.bank_open = '0;
      end
      SDCD_CMD_ACT: begin
        d.bank_open[ba] = 1'b1;
        d.row           = addr;
      end
      SDCD_CMD_WR, SDCD_CMD_RD: begin
        d.col        = addr[COL_W-1:0];
        d.bc4        = bc4_sel;
        d.burst_wr   = (cmd == SDCD_CMD_WR);
        d.burst_ap   = ap_bit;
        d.burst_bank = ba;
        d.burst_cnt  = bc4_sel ? SDCD_BURST_CYC_BC4 : SDCD_BURST_CYC_BL8;
      end
      SDCD_CMD_ILL: begin
        d.err_ill = 1'b1;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q           <= '0;
      q.st        <= SDCD_ST_NORMAL;
      q.cke_prev  <= 1'b0;
      q.ctrl_term <= SDCD_CTRL_TERM_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata              = q.prdata;
  assign cmd_valid           = q.cmd_valid;
  assign cmd_code            = q.cmd;
  assign cmd_bank            = q.bank;
  assign row_addr            = q.row;
  assign column_addr         = q.col;
  assign auto_precharge_flag = q.ap;
  assign burst_chop_select   = q.bc4;
  assign burst_active        = (q.burst_cnt != 3'h0);
  assign burst_write         = q.burst_wr;
  // Refresh pulses only come from a decoded refresh, never in power-down
  assign refresh_pulse       = q.cmd_valid & (q.cmd == SDCD_CMD_REF);
  assign power_down          = (q.st == SDCD_ST_PDN);
  assign self_refresh        = (q.st == SDCD_ST_SREF);
  // Combinational so the wake is seen before any clock history exists
  assign self_refresh_exit   = (q.st == SDCD_ST_SREF) & cke;
  // Termination is a side path only; it never enters the decoder
  assign termination_on      = odt & q.ctrl_term & (q.st != SDCD_ST_SREF);
  assign banks_open          = q.bank_open;

endmodule : sdcd_core
`default_nettype wire

// ---- dv/sdcd_ctrl_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module sdcd_ctrl_model #(
  parameter int BA_W  = 3,
  parameter int ROW_W = 14
) (
  input wire logic         pclk,
  output logic             cke,
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic [BA_W-1:0]  ba,
  output logic [ROW_W-1:0] addr
);
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h0F;
    ba = '0;
    addr = '0;
  end
  // Lines change just after an edge and stand through the next one
  task automatic drive(input logic [3:0] c, input logic k, input logic [BA_W-1:0] b,
                       input logic [ROW_W-1:0] a);
    cke <= k;
    cs_n <= c[3];
    // Deselected lines are don't-care: flip them so stale values never help
    {ras_n, cas_n, we_n} <= c[3] ? ~{ras_n, cas_n, we_n} : c[2:0];
    ba <= c[3] ? ~ba : b;
    addr <= c[3] ? ~addr : a;
  endtask : drive
  task automatic issue(input logic [3:0] c, input logic k, input logic [BA_W-1:0] b,
                       input logic [ROW_W-1:0] a);
    @(posedge pclk);
    drive(c, k, b, a);
    @(posedge pclk);
    // Idle cycles carry a no-operation so nothing stray is registered
    drive(4'h7, k, b, a);
  endtask : issue
endmodule : sdcd_ctrl_model
`default_nettype wire

// ---- dv/sdcd_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module sdcd_properties
  import sdcd_pkg::*;
#(
  parameter int BA_W  = 3,
  parameter int ROW_W = 14,
  parameter int COL_W = 10
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 cke,
  input wire logic                 cs_n,
  input wire logic                 ras_n,
  input wire logic                 cas_n,
  input wire logic                 we_n,
  input wire logic [BA_W-1:0]      ba,
  input wire logic [ROW_W-1:0]     addr,
  input wire logic                 cmd_valid,
  input wire logic [4:0]           cmd_code,
  input wire logic [BA_W-1:0]      cmd_bank,
  input wire logic [ROW_W-1:0]     row_addr,
  input wire logic [COL_W-1:0]     column_addr,
  input wire logic                 auto_precharge_flag,
  input wire logic                 burst_active,
  input wire logic                 refresh_pulse,
  input wire logic                 power_down,
  input wire logic                 self_refresh,
  input wire logic [(1<<BA_W)-1:0] banks_open
);
  logic       cke_q;
  logic       go;
  logic [2:0] rcw;
  // Mirrors the decoder's own clock-enable history, so it too starts low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cke_q <= 1'b0;
    else cke_q <= cke;
  end
  assign go  = cke_q & cke & ~cs_n & ~self_refresh;
  assign rcw = {ras_n, cas_n, we_n};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wr_decode_a:
    assert property (go && rcw == 3'b100 && !burst_active |=> cmd_valid
      && cmd_code == SDCD_CMD_WR && cmd_bank == $past(ba)) else $error("write missed");
  rd_decode_a:
    assert property (go && rcw == 3'b101 && !burst_active |=> cmd_code == SDCD_CMD_RD
      && column_addr == $past(addr[COL_W-1:0])
      && auto_precharge_flag == $past(addr[SDCD_AP_BIT])) else $error("read missed");
  act_row_a:
    assert property (go && rcw == 3'b011 |=> cmd_code == SDCD_CMD_ACT
      && row_addr == $past(addr) && banks_open[$past(ba)]) else $error("activate missed");
  ref_pulse_a:
    assert property (go && rcw == 3'b001 |=> refresh_pulse && cmd_code == SDCD_CMD_REF)
      else $error("refresh missed");
  pdn_noref_a:
    assert property (power_down |=> !refresh_pulse) else $error("refresh in power-down");
  nop_quiet_a:
    assert property (cke_q && cke && !self_refresh && (cs_n || rcw == 3'b111)
      |=> !cmd_valid) else $error("idle command decoded");
  burst_hold_a:
    assert property ($rose(burst_active) |-> burst_active [*2]) else $error("burst cut");
  pd_entry_a:
    assert property (cke_q && !cke && (cs_n || rcw == 3'b111) && !self_refresh
      && !power_down |=> power_down) else $error("no power-down");
  sr_exit_a:
    assert property (self_refresh && cke |=> !self_refresh) else $error("no sref exit");
endmodule : sdcd_properties
bind sdcd_core sdcd_properties #(.BA_W(BA_W), .ROW_W(ROW_W), .COL_W(COL_W)) prop_u (.*);
`default_nettype wire

// ---- dv/sdram_command_decoder_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module sdram_command_decoder_test;
  import sdcd_pkg::*;
  localparam logic [3:0] C_MRS = 4'h0;
  localparam logic [3:0] C_REF = 4'h1;
  localparam logic [3:0] C_PRE = 4'h2;
  localparam logic [3:0] C_ACT = 4'h3;
  localparam logic [3:0] C_WR  = 4'h4;
  localparam logic [3:0] C_RD  = 4'h5;
  localparam logic [3:0] C_ZQ  = 4'h6;
  localparam logic [3:0] C_NOP = 4'h7;
  localparam logic [3:0] C_DES = 4'h8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q, odt;
  logic        cke, cs_n, ras_n, cas_n, we_n, cmd_valid, auto_precharge_flag;
  logic        burst_chop_select, burst_active, burst_write, refresh_pulse;
  logic        power_down, self_refresh, self_refresh_exit, termination_on;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [2:0]  ba, cmd_bank;
  logic [13:0] addr, row_addr;
  logic [9:0]  column_addr;
  logic [4:0]  cmd_code;
  logic [7:0]  banks_open;
  int          miscompares = 0;
  int          total_checks = 0;
  sdcd_core dut_u (.*);
  sdcd_ctrl_model ctl_u (.*);
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] exp, input logic [31:0] act);
    total_checks++;
    if (act !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cmd(input logic [3:0] c, input logic k, input logic [2:0] b,
                     input logic [13:0] a);
    ctl_u.issue(c, k, b, a);
    #1;
  endtask : cmd
  // Burst must stand for exactly n cycles while only NOPs follow
  task automatic burst(input int n);
    chk(32'h1, {31'h0, burst_active});
    repeat (n - 1) @(posedge pclk);
    #1 chk(32'h1, {31'h0, burst_active});
    @(posedge pclk);
    #1 chk(32'h0, {31'h0, burst_active});
  endtask : burst
  task automatic t_regs();
    cmd(C_NOP, 1'b1, 3'h0, 14'h0);
    chk({1'b1, 5'h0E}, {cmd_valid, cmd_code});
    apb(1'b0, SDCD_OFF_CTRL, 32'h0);
    chk(32'h1, rd_q);
    apb(1'b0, 12'h0FC, 32'h0);
    chk(32'h1, {31'h0, err_q});
    $display("t_regs done");
  endtask : t_regs
  task automatic t_fixed();
    cmd(C_ACT, 1'b1, 3'h2, 14'h1ABC);
    chk({5'h08, 14'h1ABC, 8'h04}, {cmd_code, row_addr, banks_open});
    cmd(C_RD, 1'b1, 3'h2, 14'h0155);
    chk({5'h0A, 10'h155, 1'b0}, {cmd_code, column_addr, burst_chop_select});
    burst(4);
    $display("t_fixed done");
  endtask : t_fixed
  task automatic t_otf();
    cmd(C_MRS, 1'b1, 3'h0, 14'h0001);
    cmd(C_MRS, 1'b1, 3'h3, 14'h00AB);
    apb(1'b0, SDCD_OFF_MR0, 32'h0);
    chk(32'h1, rd_q);
    apb(1'b0, SDCD_OFF_MR3, 32'h0);
    chk(32'hAB, rd_q);
    cmd(C_RD, 1'b1, 3'h2, 14'h1055);
    chk({5'h0A, 1'b0}, {cmd_code, burst_chop_select});
    burst(4);
    cmd(C_RD, 1'b1, 3'h2, 14'h0055);
    chk({5'h0A, 1'b1}, {cmd_code, burst_chop_select});
    burst(2);
    cmd(C_RD, 1'b1, 3'h2, 14'h1011);
    cmd(C_WR, 1'b1, 3'h2, 14'h1022);
    chk({5'h0A, 10'h011}, {cmd_code, column_addr});
    apb(1'b0, SDCD_OFF_STATUS, 32'h0);
    chk(32'h1, {31'h0, rd_q[SDCD_ST_ERR_CUT]});
    apb(1'b1, SDCD_OFF_STATUS, 32'h100);
    apb(1'b0, SDCD_OFF_STATUS, 32'h0);
    chk(32'h0, {31'h0, rd_q[SDCD_ST_ERR_CUT]});
    cmd(C_WR, 1'b1, 3'h2, 14'h0477);
    chk({5'h09, 2'h3}, {cmd_code, auto_precharge_flag, burst_write});
    chk(32'h1, {31'h0, burst_chop_select});
    burst(2);
    @(posedge pclk);
    #1 chk(32'h0, {24'h0, banks_open});
    $display("t_otf done");
  endtask : t_otf
  task automatic t_prezq();
    cmd(C_ACT, 1'b1, 3'h5, 14'h0010);
    cmd(C_PRE, 1'b1, 3'h5, 14'h0000);
    chk({5'h06, 8'h00}, {cmd_code, banks_open});
    cmd(C_ACT, 1'b1, 3'h1, 14'h0020);
    cmd(C_PRE, 1'b1, 3'h6, 14'h0400);
    chk({5'h07, 8'h00}, {cmd_code, banks_open});
    cmd(C_ZQ, 1'b1, 3'h0, 14'h0400);
    chk(32'h0B, {27'h0, cmd_code});
    cmd(C_ZQ, 1'b1, 3'h0, 14'h0000);
    chk(32'h0C, {27'h0, cmd_code});
    // Clock enable falling under an activate is no legal transition
    cmd(C_ACT, 1'b0, 3'h0, 14'h0);
    chk(32'h10, {27'h0, cmd_code});
    apb(1'b0, SDCD_OFF_STATUS, 32'h0);
    chk(32'h1, {31'h0, rd_q[SDCD_ST_ERR_ILL]});
    cmd(C_NOP, 1'b1, 3'h0, 14'h0);
    cmd(C_MRS, 1'b1, 3'h0, 14'h0002);
    cmd(C_RD, 1'b1, 3'h0, 14'h1000);
    chk({5'h0A, 1'b1}, {cmd_code, burst_chop_select});
    burst(2);
    $display("t_prezq done");
  endtask : t_prezq
  task automatic t_power();
    cmd(C_REF, 1'b1, 3'h0, 14'h0);
    chk({1'b1, 5'h03}, {refresh_pulse, cmd_code});
    cmd(C_NOP, 1'b0, 3'h0, 14'h0);
    chk(32'h1, {31'h0, power_down});
    cmd(C_REF, 1'b0, 3'h0, 14'h0);
    chk(2'b01, {refresh_pulse, power_down});
    cmd(C_DES, 1'b1, 3'h0, 14'h0);
    chk({1'b0, 5'h0E}, {power_down, cmd_code});
    @(posedge pclk);
    odt <= 1'b1;
    // Banks are all idle here, so self refresh may be entered
    cmd(C_REF, 1'b0, 3'h0, 14'h0);
    chk(3'b100, {self_refresh, termination_on, self_refresh_exit});
    // Wake by hand so the combinational exit flag is seen before the edge
    @(posedge pclk);
    ctl_u.drive(C_DES, 1'b1, 3'h0, 14'h0);
    #1 chk(32'h1, {31'h0, self_refresh_exit});
    cmd(C_NOP, 1'b1, 3'h0, 14'h0);
    chk({2'b01, 5'h05}, {self_refresh, termination_on, cmd_code});
    repeat (512) @(posedge pclk);
    cmd(C_WR, 1'b1, 3'h0, 14'h1010);
    chk(32'h09, {27'h0, cmd_code});
    $display("t_power done");
  endtask : t_power
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    {presetn, psel, penable, pwrite, odt} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_fixed();
    t_otf();
    t_prezq();
    t_power();
    tally_and_finish();
  end
endmodule : sdram_command_decoder_test
`default_nettype wire
